// ### verilog/tcpo_regs.svh
`ifndef TCPO_REGS_SVH
`define TCPO_REGS_SVH

// register byte offsets on the plain register port
`define TCPO_ADDR_CTRL        4'h0
`define TCPO_ADDR_STATUS      4'h4
`define TCPO_ADDR_EVCNT       4'h8

// control register layout and reset value
`define TCPO_CTRL_W           4
`define TCPO_CTRL_RST         4'h1
`define TCPO_CTRL_EN_BIT      0
`define TCPO_CTRL_MASK_A_BIT  1
`define TCPO_CTRL_MASK_B_BIT  2
`define TCPO_CTRL_HOLD_BIT    3

// status register layout
`define TCPO_STAT_LANE_A_BIT  0
`define TCPO_STAT_LANE_B_BIT  1
`define TCPO_STAT_MODE2_BIT   2
`define TCPO_STAT_STRAP_BIT   3
`define TCPO_STAT_ATTACH_BIT  4
`define TCPO_STAT_ORIENT_BIT  5
`define TCPO_STAT_ATT_A_BIT   6
`define TCPO_STAT_ATT_B_BIT   7
`define TCPO_STAT_LAST_B_BIT  8

// event counter register layout
`define TCPO_EVCNT_ATT_LSB    0
`define TCPO_EVCNT_CHG_LSB    16
`define TCPO_EVCNT_FIELD_W    16

// reset values of sampled pins and data
`define TCPO_PINS_RST         4'h0
`define TCPO_RDATA_RST        32'h0000_0000
`define TCPO_SETTLE_RST       2'h0

`endif

// ### verilog/tcpo_pkg.sv
package tcpo_pkg;

    // connector control inputs as one sampled group
    typedef struct packed {
        logic attach;
        logic orient;
        logic att_a;
        logic att_b;
    } tcpo_pins_s;

    // lane enable pair
    typedef struct packed {
        logic a;
        logic b;
    } tcpo_lanes_s;

    // connector control mode chosen by the mode-select pin
    typedef enum logic {
        TCPO_MODE1 = 1'h0,
        TCPO_MODE2 = 1'h1
    } tcpo_mode_e;

    // lane power state, one-hot
    typedef enum logic [3:0] {
        TCPO_ST_OFF = 4'h1,
        TCPO_ST_A   = 4'h2,
        TCPO_ST_B   = 4'h4,
        TCPO_ST_AB  = 4'h8
    } tcpo_state_e;

endpackage

// ### verilog/tcpo_sense.sv
`timescale 1ns/100ps
module tcpo_sense (
    // raw sampled pins
    input  wire tcpo_pkg::tcpo_pins_s raw,
    input  wire logic                 strap,
    // pins in active-high sense
    output tcpo_pkg::tcpo_pins_s      norm
);

    // strap high turns every control input active low
    assign norm = raw ^ {$bits(tcpo_pkg::tcpo_pins_s){strap}};

endmodule

// ### verilog/tcpo_lane_decode.sv
`timescale 1ns/100ps
module tcpo_lane_decode (
    // normalised pins and mode
    input  wire tcpo_pkg::tcpo_pins_s norm,
    input  wire tcpo_pkg::tcpo_mode_e mode,
    // requested lanes
    output tcpo_pkg::tcpo_lanes_s     req
);

    // mode 1 picks one lane from orientation; mode 2 takes each attach as is
    function automatic tcpo_pkg::tcpo_lanes_s decode(input tcpo_pkg::tcpo_pins_s p,
                                                     input tcpo_pkg::tcpo_mode_e m);
        tcpo_pkg::tcpo_lanes_s l;
        l = '0;
        case (m)
            tcpo_pkg::TCPO_MODE1: begin
                l.a = p.attach & ~p.orient;
                l.b = p.attach & p.orient;
            end
            tcpo_pkg::TCPO_MODE2: begin
                l.a = p.att_a;
                l.b = p.att_b;
            end
            default: begin
                l = '0;
            end
        endcase
        return l;
    endfunction

    // decode is purely combinational; the top registers the result
    assign req = decode(norm, mode);

endmodule

// ### verilog/tcpo_orient_enable.sv
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/100ps
`include "tcpo_regs.svh"
// Behaviour
// - strap low: orientation 1 B, 0 A
// - strap high: orientation 1 A, 0 B
// - mode 1 lane only while attach asserted
// - mode 2 only with mode-select high
// - mode 2: attach A powers lane A
// - mode 2: attach B powers lane B
// - mode 2: deasserted attach keeps lane off
// - strap low: all inputs active high
// - strap high: all inputs active low
// - unconnected strap reads low, active high
// - attach present enables lanes, else disabled
// - mode-select low: mode 1, ignore per-orientation
module tcpo_orient_enable #(
    parameter int CNT_W = `TCPO_EVCNT_FIELD_W
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // connector control pins
    input  wire logic        attach_in,
    input  wire logic        orientation_in,
    input  wire logic        attach_orient_a_in,
    input  wire logic        attach_orient_b_in,
    input  wire logic        input_polarity_strap,
    input  wire logic        ctrl_mode_select,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // lane power enables
    output logic             lane_a_en,
    output logic             lane_b_en
);

    tcpo_pkg::tcpo_pins_s           pin_reg;
    tcpo_pkg::tcpo_pins_s           norm_pins;
    tcpo_pkg::tcpo_lanes_s          req;
    tcpo_pkg::tcpo_lanes_s          lane_ok;
    tcpo_pkg::tcpo_mode_e           mode_reg;
    tcpo_pkg::tcpo_state_e          state_reg;
    tcpo_pkg::tcpo_state_e          state_next;
    logic                           strap_reg;
    logic [`TCPO_CTRL_W-1:0]        ctrl_reg;
    logic                           lane_a_reg;
    logic                           lane_b_reg;
    logic                           last_b_reg;
    logic [CNT_W-1:0]               att_cnt_reg;
    logic [CNT_W-1:0]               chg_cnt_reg;
    logic [31:0]                    rdata_reg;
    logic [31:0]                    status_word;
    logic [31:0]                    evcnt_word;
    logic                           ctrl_en;
    logic                           hold;
    logic                           evcnt_clr;
    logic [1:0]                     settle_reg;
    logic                           settled;
    logic                           ctrl_pass;

    // pins are taken as synchronous; one flop stage gives a clean sample
    // pull-down default
    // an open strap pin arrives here as 0 via its pull-down, so sense is active high
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_reg   <= `TCPO_PINS_RST;
            strap_reg <= 1'h0;
            mode_reg  <= tcpo_pkg::TCPO_MODE1;
        end else begin
            pin_reg   <= {attach_in, orientation_in, attach_orient_a_in, attach_orient_b_in};
            strap_reg <= input_polarity_strap;
            mode_reg  <= tcpo_pkg::tcpo_mode_e'(ctrl_mode_select);
        end
    end

    // input sense
    // one strap flips attach, orientation and both per-orientation inputs
    tcpo_sense u_sense (
        .raw   (pin_reg),
        .strap (strap_reg),
        .norm  (norm_pins)
    );

    // mode decode
    // mode-select low uses attach and orientation, high uses per-orientation attach
    tcpo_lane_decode u_decode (
        .norm (norm_pins),
        .mode (mode_reg),
        .req  (req)
    );

    // software gating: enable, per-lane mask, and hold freezes the lane state
    assign ctrl_en = ctrl_reg[`TCPO_CTRL_EN_BIT];
    assign hold    = ctrl_reg[`TCPO_CTRL_HOLD_BIT];
    assign lane_ok.a = req.a & ctrl_en & ~ctrl_reg[`TCPO_CTRL_MASK_A_BIT];
    assign lane_ok.b = req.b & ctrl_en & ~ctrl_reg[`TCPO_CTRL_MASK_B_BIT];

    // attach gates lanes
    // no request means off, so idle lanes stay powered down
    always_comb begin
        state_next = state_reg;
        if (!hold) begin
            case ({lane_ok.a, lane_ok.b})
                2'h0:    state_next = tcpo_pkg::TCPO_ST_OFF;
                2'h2:    state_next = tcpo_pkg::TCPO_ST_A;
                2'h1:    state_next = tcpo_pkg::TCPO_ST_B;
                2'h3:    state_next = tcpo_pkg::TCPO_ST_AB;
                default: state_next = tcpo_pkg::TCPO_ST_OFF;
            endcase
        end
    end

    // state and the lane outputs update together so outputs stay flop driven
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg  <= tcpo_pkg::TCPO_ST_OFF;
            lane_a_reg <= 1'h0;
            lane_b_reg <= 1'h0;
        end else begin
            state_reg <= state_next;
            case (state_next)
                tcpo_pkg::TCPO_ST_A: begin
                    lane_a_reg <= 1'h1;
                    lane_b_reg <= 1'h0;
                end
                tcpo_pkg::TCPO_ST_B: begin
                    lane_a_reg <= 1'h0;
                    lane_b_reg <= 1'h1;
                end
                tcpo_pkg::TCPO_ST_AB: begin
                    lane_a_reg <= 1'h1;
                    lane_b_reg <= 1'h1;
                end
                default: begin
                    lane_a_reg <= 1'h0;
                    lane_b_reg <= 1'h0;
                end
            endcase
        end
    end

    // remembers which single lane was last powered, for software
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            last_b_reg <= 1'h0;
        end else if (state_next == tcpo_pkg::TCPO_ST_B) begin
            last_b_reg <= 1'h1;
        end else if (state_next == tcpo_pkg::TCPO_ST_A) begin
            last_b_reg <= 1'h0;
        end
    end

    // control register write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_reg <= `TCPO_CTRL_RST;
        end else if (reg_wr && reg_addr == `TCPO_ADDR_CTRL) begin
            ctrl_reg <= reg_wdata[`TCPO_CTRL_W-1:0];
        end
    end

    // event counters wrap; an event in the clearing cycle counts as one
    assign evcnt_clr = reg_wr && (reg_addr == `TCPO_ADDR_EVCNT);
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            att_cnt_reg <= '0;
            chg_cnt_reg <= '0;
        end else begin
            if (state_reg == tcpo_pkg::TCPO_ST_OFF && state_next != tcpo_pkg::TCPO_ST_OFF) begin
                att_cnt_reg <= evcnt_clr ? CNT_W'(1) : att_cnt_reg + CNT_W'(1);
            end else if (evcnt_clr) begin
                att_cnt_reg <= '0;
            end
            if (state_next != state_reg) begin
                chg_cnt_reg <= evcnt_clr ? CNT_W'(1) : chg_cnt_reg + CNT_W'(1);
            end else if (evcnt_clr) begin
                chg_cnt_reg <= '0;
            end
        end
    end

    // status word shows lanes, mode, strap and the raw sampled pins
    always_comb begin
        status_word = '0;
        status_word[`TCPO_STAT_LANE_A_BIT] = lane_a_reg;
        status_word[`TCPO_STAT_LANE_B_BIT] = lane_b_reg;
        status_word[`TCPO_STAT_MODE2_BIT]  = (mode_reg == tcpo_pkg::TCPO_MODE2);
        status_word[`TCPO_STAT_STRAP_BIT]  = strap_reg;
        status_word[`TCPO_STAT_ATTACH_BIT] = pin_reg.attach;
        status_word[`TCPO_STAT_ORIENT_BIT] = pin_reg.orient;
        status_word[`TCPO_STAT_ATT_A_BIT]  = pin_reg.att_a;
        status_word[`TCPO_STAT_ATT_B_BIT]  = pin_reg.att_b;
        status_word[`TCPO_STAT_LAST_B_BIT] = last_b_reg;
    end

    // counters packed side by side; CNT_W above the field width is not supported
    always_comb begin
        evcnt_word = '0;
        evcnt_word[`TCPO_EVCNT_ATT_LSB +: CNT_W] = att_cnt_reg;
        evcnt_word[`TCPO_EVCNT_CHG_LSB +: CNT_W] = chg_cnt_reg;
    end

    // read data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_reg <= `TCPO_RDATA_RST;
        end else if (reg_rd) begin
            case (reg_addr)
                `TCPO_ADDR_CTRL:   rdata_reg <= {{(32-`TCPO_CTRL_W){1'h0}}, ctrl_reg};
                `TCPO_ADDR_STATUS: rdata_reg <= status_word;
                `TCPO_ADDR_EVCNT:  rdata_reg <= evcnt_word;
                default:           rdata_reg <= `TCPO_RDATA_RST;
            endcase
        end else begin
            rdata_reg <= `TCPO_RDATA_RST;
        end
    end

    // outputs
    assign reg_rdata = rdata_reg;
    assign lane_a_en = lane_a_reg;
    assign lane_b_en = lane_b_reg;

    // checking helpers: pipeline primed after reset, software not gating
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            settle_reg <= `TCPO_SETTLE_RST;
        end else begin
            settle_reg <= {settle_reg[0], 1'h1};
        end
    end
    assign settled   = settle_reg[1];
    assign ctrl_pass = ctrl_en & ~hold & ~ctrl_reg[`TCPO_CTRL_MASK_A_BIT] & ~ctrl_reg[`TCPO_CTRL_MASK_B_BIT];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    orient_low_sense_a: assert property (
        settled && $past(ctrl_pass) && !$past(ctrl_mode_select, 2) && !$past(input_polarity_strap, 2)
        && $past(attach_in, 2)
        |-> (lane_b_en == $past(orientation_in, 2)) && (lane_a_en == !$past(orientation_in, 2)))
        else $error("mode 1 lane wrong for strap low");

    orient_high_sense_a: assert property (
        settled && $past(ctrl_pass) && !$past(ctrl_mode_select, 2) && $past(input_polarity_strap, 2)
        && !$past(attach_in, 2)
        |-> (lane_a_en == $past(orientation_in, 2)) && (lane_b_en == !$past(orientation_in, 2)))
        else $error("mode 1 lane wrong for strap high");

    mode1_detach_off_a: assert property (
        settled && !$past(ctrl_mode_select, 2) && !$past(hold)
        && ($past(attach_in, 2) == $past(input_polarity_strap, 2))
        |-> !lane_a_en && !lane_b_en)
        else $error("lane powered without attach in mode 1");

    dual_lane_mode_a: assert property (
        settled && lane_a_en && lane_b_en && $changed(state_reg) |-> $past(ctrl_mode_select, 2))
        else $error("both lanes enabled outside mode 2");

    mode2_lane_a_a: assert property (
        settled && $past(ctrl_pass) && $past(ctrl_mode_select, 2) && !$past(input_polarity_strap, 2)
        |-> lane_a_en == $past(attach_orient_a_in, 2))
        else $error("mode 2 lane A does not follow its attach");

    mode2_lane_b_a: assert property (
        settled && $past(ctrl_pass) && $past(ctrl_mode_select, 2) && $past(input_polarity_strap, 2)
        |-> lane_b_en == !$past(attach_orient_b_in, 2))
        else $error("mode 2 lane B does not follow its attach");

    mode2_idle_off_a: assert property (
        settled && $past(ctrl_mode_select, 2) && !$past(hold)
        && ($past(attach_orient_a_in, 2) == $past(input_polarity_strap, 2))
        |-> !lane_a_en)
        else $error("mode 2 lane A on while attach deasserted");

    mode1_ignore_alt_a: assert property (
        settled && !$past(ctrl_mode_select, 2) && !$past(ctrl_mode_select, 3)
        && ($past(ctrl_reg) == $past(ctrl_reg, 2))
        && $past(settled) && $past(attach_in, 2) == $past(attach_in, 3)
        && $past(orientation_in, 2) == $past(orientation_in, 3)
        && $past(input_polarity_strap, 2) == $past(input_polarity_strap, 3)
        |-> $stable(lane_a_en) && $stable(lane_b_en))
        else $error("mode 1 lanes moved without attach or orientation change");

    mode1_one_lane_a: assert property (
        settled && !$past(ctrl_mode_select, 2) && !$past(hold) |-> !(lane_a_en && lane_b_en))
        else $error("mode 1 enabled both lanes");

    // read data only in the cycle after a read strobe
    rdata_window_a: assert property (
        !$past(reg_rd) |-> reg_rdata == `TCPO_RDATA_RST)
        else $error("read data outside its cycle");

endmodule

// ### test/tcpo_attach_ctrl.sv
`timescale 1ns/100ps
// stand-in for the external attach controller and the two strap pins
module tcpo_attach_ctrl (
    // logical connector state asked for by the bench
    input  wire logic want_attach,
    input  wire logic want_flip,
    input  wire logic want_a,
    input  wire logic want_b,
    // straps, each with a flag saying whether the pin is wired at all
    input  wire logic strap_level,
    input  wire logic strap_conn,
    input  wire logic mode_level,
    input  wire logic mode_conn,
    // pins toward the block
    output logic      attach_in,
    output logic      orientation_in,
    output logic      attach_orient_a_in,
    output logic      attach_orient_b_in,
    output logic      input_polarity_strap,
    output logic      ctrl_mode_select
);
    // strap pull-down
    // an open strap pin settles low through its internal pull-down
    assign input_polarity_strap = strap_conn & strap_level;
    // mode pin pull-down
    // mode 2 is reached only by holding the pin high, open means mode 1
    assign ctrl_mode_select     = mode_conn & mode_level;
    // attach sense
    // every line is driven in the sense picked by the strap, never left stale
    assign attach_in            = want_attach ^ input_polarity_strap;
    assign orientation_in       = want_flip ^ input_polarity_strap;
    assign attach_orient_a_in   = want_a ^ input_polarity_strap;
    assign attach_orient_b_in   = want_b ^ input_polarity_strap;
endmodule

// ### test/tb_tcpo_orient_enable.sv
`timescale 1ns/100ps
module tb_tcpo_orient_enable;
    logic                  sys_clk;
    logic                  rst;
    logic [3:0]            reg_addr;
    logic [31:0]           reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [31:0]           reg_rdata;
    logic [31:0]           rd_word;
    logic                  lane_a_en;
    logic                  lane_b_en;
    logic                  attach_in;
    logic                  orientation_in;
    logic                  attach_orient_a_in;
    logic                  attach_orient_b_in;
    logic                  input_polarity_strap;
    logic                  ctrl_mode_select;
    logic [7:0]            want;
    tcpo_pkg::tcpo_lanes_s exp;
    int                    n_mismatch;
    int                    n_tests;
    int                    cycles;

    // far-side controller, commanded through the want vector
    tcpo_attach_ctrl tcpo_attach_ctrl_i (
        .want_attach          (want[7]),
        .want_flip            (want[6]),
        .want_a               (want[5]),
        .want_b               (want[4]),
        .strap_level          (want[3]),
        .strap_conn           (want[2]),
        .mode_level           (want[1]),
        .mode_conn            (want[0]),
        .attach_in            (attach_in),
        .orientation_in       (orientation_in),
        .attach_orient_a_in   (attach_orient_a_in),
        .attach_orient_b_in   (attach_orient_b_in),
        .input_polarity_strap (input_polarity_strap),
        .ctrl_mode_select     (ctrl_mode_select)
    );

    tcpo_orient_enable tcpo_orient_enable_i (
        .sys_clk              (sys_clk),
        .rst                  (rst),
        .attach_in            (attach_in),
        .orientation_in       (orientation_in),
        .attach_orient_a_in   (attach_orient_a_in),
        .attach_orient_b_in   (attach_orient_b_in),
        .input_polarity_strap (input_polarity_strap),
        .ctrl_mode_select     (ctrl_mode_select),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .lane_a_en            (lane_a_en),
        .lane_b_en            (lane_b_en)
    );

    // 125 MHz clock
    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end

    // counts, verdict and end of run, shared with the hang guard
    task end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task cmp_word(input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected word at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task cmp_lanes(input tcpo_pkg::tcpo_lanes_s e);
        n_tests++;
        if ({lane_a_en, lane_b_en} !== e) begin
            n_mismatch++;
            $display("unexpected lanes at %0t: got %h expected %h", $time, {lane_a_en, lane_b_en}, e);
        end
    endtask

    // one-cycle write strobe
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'h0;
    endtask

    // one-cycle read strobe, data taken in the following cycle only
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'h0;
        #1;
        d = reg_rdata;
    endtask

    // new connector state, then the fixed two-edge pin to lane latency
    task apply(input logic [7:0] v);
        @(posedge sys_clk);
        want <= v;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    // hang guard, far above the roughly 165 cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        rst        = 1'h1;
        reg_addr   = 4'h0;
        reg_wdata  = 32'h0000_0000;
        reg_wr     = 1'h0;
        reg_rd     = 1'h0;
        want       = 8'h05;
        n_mismatch = 0;
        n_tests    = 0;
        cycles     = 0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'h0;
        rd(4'h0, rd_word);
        cmp_word(32'h0000_0001, rd_word);
        rd(4'hc, rd_word);
        cmp_word(32'h0000_0000, rd_word);
        apply(8'h05);
        cmp_lanes('{a: 1'h0, b: 1'h0});
        $display("test reset done");
        // mode 1: strap, attach, orientation, with noise on the mode 2 lines
        for (int i = 0; i < 16; i++) begin
            apply({i[2], i[1], i[0], ~i[0], i[3], 3'h4});
            exp = '{a: i[2] & ~i[1], b: i[2] & i[1]};
            cmp_lanes(exp);
        end
        $display("test mode 1 done");
        // mode 2: strap and both attach lines, with noise on the mode 1 lines
        for (int i = 0; i < 16; i++) begin
            apply({i[0], ~i[0], i[2], i[1], i[3], 3'h7});
            exp = '{a: i[2], b: i[1]};
            cmp_lanes(exp);
        end
        $display("test mode 2 done");
        // open strap and open mode pin, both driven high on the far side
        apply(8'hba);
        cmp_lanes('{a: 1'h1, b: 1'h0});
        apply(8'hca);
        cmp_lanes('{a: 1'h0, b: 1'h1});
        $display("test open straps done");
        // disable, restore, then a counted attach from lanes off
        wr(4'h0, 32'h0000_0000);
        repeat (3) @(posedge sys_clk);
        #1;
        cmp_lanes('{a: 1'h0, b: 1'h0});
        rd(4'h0, rd_word);
        cmp_word(32'h0000_0000, rd_word);
        wr(4'h0, 32'h0000_0001);
        apply(8'h04);
        repeat (2) @(posedge sys_clk);
        wr(4'h8, 32'h0000_0000);
        apply(8'h84);
        cmp_lanes('{a: 1'h1, b: 1'h0});
        rd(4'h8, rd_word);
        cmp_word(32'h0001_0001, rd_word);
        rd(4'h4, rd_word);
        cmp_word(32'h0000_0011, rd_word);
        // mask A drops lane A; hold then keeps lane A through a flip
        wr(4'h0, 32'h0000_0003);
        repeat (3) @(posedge sys_clk);
        #1;
        cmp_lanes('{a: 1'h0, b: 1'h0});
        wr(4'h0, 32'h0000_0001);
        wr(4'h0, 32'h0000_0009);
        apply(8'hc4);
        cmp_lanes('{a: 1'h1, b: 1'h0});
        // releasing hold lets the flipped request through
        wr(4'h0, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        #1;
        cmp_lanes('{a: 1'h0, b: 1'h1});
        rd(4'h4, rd_word);
        cmp_word(32'h0000_0132, rd_word);
        // mask B in mode 2 leaves only lane A of the requested pair
        wr(4'h0, 32'h0000_0005);
        apply(8'h37);
        cmp_lanes('{a: 1'h1, b: 1'h0});
        rd(4'h4, rd_word);
        cmp_word(32'h0000_00c5, rd_word);
        $display("test registers done");
        end_sim();
    end
endmodule
